/* File: rtl/sstp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low reset already released in step with it.
`default_nettype none
module sstp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } sstp_fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  sstp_fifo_state_t st_r;
  sstp_fifo_state_t st_nxt;
  logic push;
  logic pop;

  assign o_in_ready = (st_r.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st_r.count != '0);
  assign o_out_data = mem[st_r.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (i_flush)
    begin
      st_nxt = '0;
    end
    else
    begin
      if (push)
      begin
        st_nxt.wr = (st_r.wr == AW'(DEPTH - 1)) ? '0 : st_r.wr + AW'(1);
      end
      if (pop)
      begin
        st_nxt.rd = (st_r.rd == AW'(DEPTH - 1)) ? '0 : st_r.rd + AW'(1);
      end
      st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Storage has no reset; contents are only read behind the count
  always_ff @(posedge i_core_clk)
  begin
    if (push && !i_flush)
    begin
      mem[st_r.wr] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/sstp_port.sv */
// Serial status text port: paced packet transmitter with a 16-byte FIFO.
// Assumes the packet source supplies bytes in the mode shown on o_mode.
//
// Behaviour
// - Both ends use 9600 baud, 8N1 framing, no parity, no handshake.
// - After reset or with no alternative chosen, default text mode is sent.
// - A configuration input selects an alternative output mode in place of text.
// - Once running, one packet is released every second, continuously.
// - Port is active only while the handheld unit is attached.
`default_nettype none
module sstp_port #(
  parameter int unsigned PACKET_CYCLES = sstp_pkg::PACKET_CYCLES,
  parameter int unsigned BIT_CYCLES = sstp_pkg::BIT_CYCLES,
  parameter int unsigned FIFO_DEPTH = sstp_pkg::FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_attached,
  input wire logic i_alt_mode_sel,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte_data,
  input wire logic i_byte_last,
  output logic o_byte_ready,
  output logic o_packet_req,
  output logic o_mode,
  output logic o_active,
  output logic o_txd,
  input wire logic i_rxd,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data
);
  localparam int unsigned PW = $clog2(PACKET_CYCLES + 1);
  localparam int unsigned BW = $clog2(BIT_CYCLES + 1);
  localparam logic [2:0] LAST_BIT = 3'(sstp_pkg::DATA_BITS - 1);

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [PW-1:0] pkt_cnt;
    logic in_packet;
    logic packet_req;
    sstp_pkg::sstp_mode_t mode;
    logic active;
    sstp_pkg::sstp_tx_state_t tx_st;
    logic [BW-1:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic txd;
    logic rx_busy;
    logic [BW-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic [7:0] rx_data;
  } sstp_state_t;

  sstp_state_t st_r;
  sstp_state_t st_nxt;
  logic rst_sync_n;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [8:0] fifo_out;
  logic fifo_push;

  assign rst_sync_n = st_r.rst_sync[1];
  // Bytes are accepted only inside a paced packet window
  assign fifo_push = i_byte_valid && st_r.in_packet && st_r.active;
  assign fifo_pop = fifo_out_valid && (st_r.tx_st == sstp_pkg::SSTP_TX_IDLE) && st_r.active;

  sstp_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rstn(rst_sync_n),
    .i_flush(!st_r.active),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data({i_byte_last, i_byte_data}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_nxt.packet_req = 1'b0;
    st_nxt.rx_valid = 1'b0;
    st_nxt.active = i_attached;
    st_nxt.mode = i_alt_mode_sel ? sstp_pkg::SSTP_MODE_ALT : sstp_pkg::SSTP_MODE_TEXT;
    o_byte_ready = fifo_in_ready && st_r.in_packet && st_r.active;
    if (!st_r.active)
    begin
      // Detached: hold line idle and restart pacing on reattach
      st_nxt.pkt_cnt = '0;
      st_nxt.in_packet = 1'b0;
      st_nxt.tx_st = sstp_pkg::SSTP_TX_IDLE;
      st_nxt.txd = sstp_pkg::IDLE_LEVEL;
      st_nxt.rx_busy = 1'b0;
    end
    else
    begin
      if (fifo_push && fifo_in_ready && i_byte_last)
      begin
        st_nxt.in_packet = 1'b0;
      end
      // One packet per interval; first request right after activation
      // A new window opening wins over the old one closing in the same cycle
      if (st_r.pkt_cnt == '0)
      begin
        st_nxt.pkt_cnt = PW'(PACKET_CYCLES - 1);
        st_nxt.packet_req = 1'b1;
        st_nxt.in_packet = 1'b1;
      end
      else
      begin
        st_nxt.pkt_cnt = st_r.pkt_cnt - PW'(1);
      end
      case (st_r.tx_st)
        sstp_pkg::SSTP_TX_IDLE:
        begin
          st_nxt.txd = sstp_pkg::IDLE_LEVEL;
          if (fifo_out_valid)
          begin
            st_nxt.tx_sh = fifo_out[7:0];
            st_nxt.tx_cnt = BW'(BIT_CYCLES - 1);
            st_nxt.txd = sstp_pkg::START_LEVEL;
            st_nxt.tx_st = sstp_pkg::SSTP_TX_START;
          end
        end
        sstp_pkg::SSTP_TX_START:
        begin
          if (st_r.tx_cnt == '0)
          begin
            st_nxt.tx_cnt = BW'(BIT_CYCLES - 1);
            st_nxt.txd = st_r.tx_sh[0];
            st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
            st_nxt.tx_bit = '0;
            st_nxt.tx_st = sstp_pkg::SSTP_TX_DATA;
          end
          else
          begin
            st_nxt.tx_cnt = st_r.tx_cnt - BW'(1);
          end
        end
        sstp_pkg::SSTP_TX_DATA:
        begin
          if (st_r.tx_cnt == '0)
          begin
            st_nxt.tx_cnt = BW'(BIT_CYCLES - 1);
            if (st_r.tx_bit == LAST_BIT)
            begin
              st_nxt.txd = sstp_pkg::STOP_LEVEL;
              st_nxt.tx_st = sstp_pkg::SSTP_TX_STOP;
            end
            else
            begin
              st_nxt.txd = st_r.tx_sh[0];
              st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
              st_nxt.tx_bit = st_r.tx_bit + 3'(1);
            end
          end
          else
          begin
            st_nxt.tx_cnt = st_r.tx_cnt - BW'(1);
          end
        end
        default:
        begin
          if (st_r.tx_cnt == '0)
          begin
            st_nxt.tx_st = sstp_pkg::SSTP_TX_IDLE;
          end
          else
          begin
            st_nxt.tx_cnt = st_r.tx_cnt - BW'(1);
          end
        end
      endcase
      // Receiver: sample mid-bit; no flow control, a byte is just reported
      if (!st_r.rx_busy)
      begin
        if (i_rxd == sstp_pkg::START_LEVEL)
        begin
          st_nxt.rx_busy = 1'b1;
          st_nxt.rx_cnt = BW'(BIT_CYCLES / 2);
          st_nxt.rx_bit = '0;
        end
      end
      else if (st_r.rx_cnt == '0)
      begin
        st_nxt.rx_cnt = BW'(BIT_CYCLES - 1);
        st_nxt.rx_bit = st_r.rx_bit + 4'(1);
        if (st_r.rx_bit == 4'(0))
        begin
          // False start: line back high at mid start bit
          st_nxt.rx_busy = (i_rxd == sstp_pkg::START_LEVEL);
        end
        else if (st_r.rx_bit <= 4'(sstp_pkg::DATA_BITS))
        begin
          st_nxt.rx_sh = {i_rxd, st_r.rx_sh[7:1]};
        end
        else
        begin
          st_nxt.rx_busy = 1'b0;
          // Framing error on a low stop bit drops the byte
          if (i_rxd == sstp_pkg::STOP_LEVEL)
          begin
            st_nxt.rx_valid = 1'b1;
            st_nxt.rx_data = st_r.rx_sh;
          end
        end
      end
      else
      begin
        st_nxt.rx_cnt = st_r.rx_cnt - BW'(1);
      end
    end
  end

  // Reset synchroniser stage runs on the raw reset
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r <= '0;
      st_r.txd <= sstp_pkg::IDLE_LEVEL;
    end
    else if (!rst_sync_n)
    begin
      st_r <= '0;
      st_r.rst_sync <= st_nxt.rst_sync;
      st_r.txd <= sstp_pkg::IDLE_LEVEL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_packet_req = st_r.packet_req;
  assign o_mode = st_r.mode;
  assign o_active = st_r.active;
  assign o_txd = st_r.txd;
  assign o_rx_valid = st_r.rx_valid;
  assign o_rx_data = st_r.rx_data;
endmodule
`default_nettype wire

/* File: shared/sstp_pkg.sv */
// Package for the serial status text port: framing, timing and shared types.
// Assumes a single 20 MHz core clock.
`default_nettype none
package sstp_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BAUD = 9600;
  // Rounded down so the bit time is never longer than nominal
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned PACKET_INTERVAL_S = 1;
  localparam int unsigned PACKET_CYCLES = CLK_HZ * PACKET_INTERVAL_S;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;

  typedef enum logic [0:0] {
    SSTP_MODE_TEXT = 1'b0,
    SSTP_MODE_ALT = 1'b1
  } sstp_mode_t;

  typedef enum logic [1:0] {
    SSTP_TX_IDLE = 2'b00,
    SSTP_TX_START = 2'b01,
    SSTP_TX_DATA = 2'b11,
    SSTP_TX_STOP = 2'b10
  } sstp_tx_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sstp_byte_t;
endpackage
`default_nettype wire

/* File: verification/sstp_peer.sv */
// Model of the serial instrument: 8N1 receiver and sender, no handshake.
// Assumes BITC core cycles per bit, same as the port under test.
`default_nettype none
module sstp_peer #(
  parameter int BITC = 8
) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [9:0] v;
  initial o_line = 1'h1;
  // Samples at bit centres; a frame with a bad stop bit is dropped
  always
  begin
    @(negedge i_line);
    repeat (BITC / 2) @(posedge i_clk);
    v[0] = i_line;
    for (int i = 1; i < 10; i++)
    begin
      repeat (BITC) @(posedge i_clk);
      v[i] = i_line;
    end
    if (!v[0] && v[9])
      got.push_back(v[8:1]);
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    @(posedge i_clk);
    #5;
    for (int i = 0; i < 10; i++)
    begin
      o_line = f[i];
      repeat (BITC) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/sstp_port_monitor.sv */
// Checker for the serial status text port, bound to sstp_port.
// Assumes one core clock and the raw active-low reset at the ports.
`default_nettype none
module sstp_port_monitor #(
  parameter int unsigned PACKET_CYCLES = 20000000
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_attached,
  input wire logic i_alt_mode_sel,
  input wire logic i_byte_valid,
  input wire logic i_byte_last,
  input wire logic o_byte_ready,
  input wire logic o_packet_req,
  input wire logic o_mode,
  input wire logic o_active,
  input wire logic o_txd,
  input wire logic o_rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rc_r;
  logic seen_r;
  logic [31:0] pc_r;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  // Pacing is judged only between two requests of one attach spell
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rc_r <= 3'h0;
      seen_r <= 1'h0;
      pc_r <= 32'h0;
    end
    else
    begin
      rc_r <= (rc_r == 3'h7) ? rc_r : rc_r + 3'h1;
      seen_r <= o_active && (seen_r || o_packet_req);
      pc_r <= o_packet_req ? 32'h0 : pc_r + 32'h1;
    end
  end
  property p_act;
    $rose(o_active) |-> $past(i_attached);
  endproperty
  a_act: assert property (p_act) else $error("active without attach");
  property p_rdy;
    o_byte_ready |-> $past(i_attached);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready while inactive");
  property p_idle;
    !o_active && !$past(o_active) |-> o_txd;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle when detached");
  property p_mode;
    rc_r == 3'h7 |-> o_mode == $past(i_alt_mode_sel);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not following select");
  property p_dflt;
    rc_r < 3'h3 |-> o_mode == sstp_pkg::SSTP_MODE_TEXT;
  endproperty
  a_dflt: assert property (p_dflt) else $error("mode not text after reset");
  property p_pls;
    o_packet_req |=> !o_packet_req;
  endproperty
  a_pls: assert property (p_pls) else $error("packet request too long");
  property p_gap;
    o_packet_req && seen_r |-> pc_r == PACKET_CYCLES - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("packet interval wrong");
  property p_last;
    i_byte_valid && o_byte_ready && i_byte_last |=> !o_byte_ready || o_packet_req;
  endproperty
  a_last: assert property (p_last) else $error("ready after last byte");
  property p_rxv;
    o_rx_valid |=> !o_rx_valid;
  endproperty
  a_rxv: assert property (p_rxv) else $error("receive pulse too long");
  c_req: cover property (o_packet_req);
  c_last: cover property (i_byte_valid && o_byte_ready && i_byte_last);
  c_rx: cover property (o_rx_valid);
endmodule
bind sstp_port sstp_port_monitor #(.PACKET_CYCLES(PACKET_CYCLES)) u_mon (.i_core_clk,
  .i_rstn, .i_attached, .i_alt_mode_sel, .i_byte_valid, .i_byte_last, .o_byte_ready,
  .o_packet_req, .o_mode, .o_active, .o_txd, .o_rx_valid);
`default_nettype wire

/* File: verification/sstp_port_tb.sv */
// Self-checking bench for sstp_port with shortened bit and packet counts.
// Assumes the peer model on the serial lines.
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module sstp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 2000;
  localparam int BC = 8;
  int n_fail = 0;
  int n_checks = 0;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic att = 1'h0;
  logic alt = 1'h0;
  logic bv = 1'h0;
  logic bl = 1'h0;
  logic [7:0] bd = 8'h00;
  logic rdy, req, mode, act, txd, rxd, rxv;
  logic [7:0] rxb;
  always #25 clk = ~clk;
  sstp_port #(.PACKET_CYCLES(PC), .BIT_CYCLES(BC)) dut (.i_core_clk(clk), .i_rstn(rstn),
    .i_attached(att), .i_alt_mode_sel(alt), .i_byte_valid(bv), .i_byte_data(bd),
    .i_byte_last(bl), .o_byte_ready(rdy), .o_packet_req(req), .o_mode(mode),
    .o_active(act), .o_txd(txd), .i_rxd(rxd), .o_rx_valid(rxv), .o_rx_data(rxb));
  sstp_peer #(.BITC(BC)) peer (.i_clk(clk), .i_line(txd), .o_line(rxd));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic wait_req();
    int w;
    w = 0;
    do
    begin
      step(1);
      w++;
    end while (req !== 1'h1 && w < PC + 50);
    `CHK(req, 1'h1)
  endtask
  // Holds valid up between bytes so it is never lowered and raised in one step
  task automatic put(input logic [7:0] d, input logic l);
    int w;
    bv = 1'h1;
    bd = d;
    bl = l;
    w = 0;
    while (rdy !== 1'h1 && w < 500)
    begin
      step(1);
      w++;
    end
    `CHK(rdy, 1'h1)
    step(1);
  endtask
  task automatic t_mode();
    alt = 1'h1;
    step(1);
    `CHK(mode, 1'h1)
    alt = 1'h0;
    step(1);
    `CHK(mode, 1'h0)
    $display("end mode");
  endtask
  // Twenty bytes overrun the 16-deep buffer, so refusal and drain both occur
  task automatic t_packet();
    int w;
    wait_req();
    for (int k = 0; k < 20; k++)
      put(8'(k * 29 + 128), k == 19);
    bv = 1'h0;
    bl = 1'h0;
    `CHK(rdy, 1'h0)
    w = 0;
    while (peer.got.size() < 20 && w < 2500)
    begin
      step(1);
      w++;
    end
    `CHK(peer.got.size(), 20)
    for (int k = 0; k < 20; k++)
      `CHK(peer.got[k], 8'(k * 29 + 128))
    $display("end packet");
  endtask
  task automatic t_pace();
    int n;
    wait_req();
    n = 0;
    do
    begin
      step(1);
      n++;
    end while (req !== 1'h1 && n < PC + 50);
    `CHK(n, PC)
    $display("end pace");
  endtask
  task automatic t_rx();
    int w;
    fork
      peer.send(8'hA5);
    join_none
    w = 0;
    while (rxv !== 1'h1 && w < 20 * BC)
    begin
      step(1);
      w++;
    end
    `CHK(rxv, 1'h1)
    `CHK(rxb, 8'hA5)
    step(2 * BC);
    $display("end rx");
  endtask
  task automatic t_detach();
    int n;
    wait_req();
    put(8'h00, 1'h1);
    bv = 1'h0;
    bl = 1'h0;
    step(3 * BC);
    att = 1'h0;
    step(2);
    `CHK(act, 1'h0)
    `CHK(txd, 1'h1)
    `CHK(rdy, 1'h0)
    n = 0;
    repeat (PC + 50)
    begin
      step(1);
      n += (req === 1'h1);
    end
    `CHK(n, 0)
    $display("end detach");
  endtask
  task automatic results();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    step(16);
    rstn = 1'h1;
    step(4);
    `CHK(txd, 1'h1)
    `CHK(mode, 1'h0)
    `CHK(act, 1'h0)
    `CHK(rdy, 1'h0)
    $display("end reset");
    att = 1'h1;
    t_mode();
    t_packet();
    t_pace();
    t_rx();
    t_detach();
    results();
  end
  initial
  begin
    #(40000 * 50);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
